// ===== bench/tb_usart_baud_rate_generator.sv
// Self-checking bench for the serial port rate generator.
// Assumes ubrg_top and the shifter model; inputs move after rising edges.
module tb_usart_baud_rate_generator;
   timeunit 1ns;
   timeprecision 1ps;
   import ubrg_pkg::*;
   typedef struct packed {
      logic [7:0]  tx;
      logic [7:0]  dv;
      logic [15:0] rb;
      logic [15:0] gap;
   } ubrg_row_s;
   // Mode, divisor, mode readback, tick spacing
   localparam ubrg_row_s ROWS [6] = '{
      '{8'h90, 8'h02, 16'h0092, 16'h000C}, '{8'h84, 8'h02, 16'h0086, 16'h0030},
      '{8'h80, 8'h01, 16'h0082, 16'h0080}, '{8'h94, 8'h03, 16'h0096, 16'h0010},
      '{8'hFF, 8'h00, 16'h00F7, 16'h0004}, '{8'hB0, 8'hFF, 16'h00B2, 16'h0400}};
   logic        ref_clk, nrst, reg_wr, reg_rd, rate_tick, rx_level, sclk_run, ext_clk;
   logic        tx_shift_empty, rx_frame_err, rx_overrun, rx_ninth_bit, receive_data_pin;
   logic [1:0]  reg_addr, pin_mode;
   logic [3:0]  sts_in;
   logic [7:0]  reg_wdata, reg_rdata, tx_ctrl, rx_ctrl;
   logic [15:0] ticks, gap, t, d;
   int          errors = 0;
   int          tests_run = 0;
   int          cycles = 0;
   ///////////////////////////////////////////////////////////////////
   ubrg_top dut (
      .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .tx_shift_empty(tx_shift_empty), .rx_frame_err(rx_frame_err),
      .rx_overrun(rx_overrun), .rx_ninth_bit(rx_ninth_bit), .ext_clk(ext_clk),
      .receive_data_pin(receive_data_pin), .rate_tick(rate_tick),
      .rx_level(rx_level), .tx_ctrl(tx_ctrl), .rx_ctrl(rx_ctrl));
   ubrg_shift_model far_end (
      .ref_clk(ref_clk), .nrst(nrst), .rate_tick(rate_tick), .sts_in(sts_in),
      .pin_mode(pin_mode), .sclk_run(sclk_run), .tx_shift_empty(tx_shift_empty),
      .rx_frame_err(rx_frame_err), .rx_overrun(rx_overrun),
      .rx_ninth_bit(rx_ninth_bit), .receive_data_pin(receive_data_pin),
      .ext_clk(ext_clk), .ticks(ticks), .gap(gap));
   ///////////////////////////////////////////////////////////////////
   always #2 ref_clk = ~ref_clk;
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      d = {8'h00, reg_rdata};
   endtask
   task automatic wait_ticks(input logic [15:0] n);
      int i;
      t = ticks;
      for (i = 0; i < 5000 && ticks - t < n; i++) @(negedge ref_clk);
   endtask
   task automatic vote(input logic [1:0] m, input logic e);
      int bad;
      bad = 0;
      @(posedge ref_clk);
      pin_mode <= m;
      repeat (100) @(negedge ref_clk);
      repeat (200) begin
         @(negedge ref_clk);
         if (rx_level !== e) bad++;
      end
      chk("vote level", 16'h0000, bad[15:0]);
   endtask
   task automatic final_report;
      $display("Checks %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 30000) begin
         errors++;
         final_report();
      end
   end
   ///////////////////////////////////////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      nrst = 1'b0;
      reg_addr = 2'h0;
      reg_wdata = 8'h00;
      {reg_wr, reg_rd, sclk_run} = 3'h0;
      sts_in = 4'h8;
      pin_mode = 2'h1;
      repeat (8) @(posedge ref_clk);
      nrst <= 1'b1;
      rd(OFS_TX_CTRL);
      chk("tx reset", 16'h0002, d);
      rd(OFS_DIVISOR);
      chk("divisor reset", 16'h0000, d);
      $display("reset test done");
      for (int k = 0; k < 6; k++) begin
         wr(OFS_TX_CTRL, ROWS[k].tx);
         wr(OFS_DIVISOR, ROWS[k].dv);
         wait_ticks(16'h0003);
         chk("tick gap", ROWS[k].gap, gap);
         rd(OFS_TX_CTRL);
         chk("tx readback", ROWS[k].rb, d);
         chk("tx view", ROWS[k].rb, {8'h00, tx_ctrl});
         rd(OFS_DIVISOR);
         chk("divisor readback", {8'h00, ROWS[k].dv}, d);
         $display("row %0d done", k);
      end
      // Rewrite mid-period must restart the count
      wr(OFS_TX_CTRL, 8'h90);
      wr(OFS_DIVISOR, 8'hFF);
      wait_ticks(16'h0002);
      repeat (100) @(negedge ref_clk);
      wr(OFS_DIVISOR, 8'hFF);
      repeat (8) @(negedge ref_clk);
      chk("tick after rewrite", t + 16'h0003, ticks);
      t = ticks;
      repeat (920) @(negedge ref_clk);
      chk("ticks after rewrite", t, ticks);
      wr(OFS_TX_CTRL, 8'h10);
      sclk_run <= 1'b1;
      wait_ticks(16'h0003);
      chk("slave gap", 16'h000A, gap);
      @(posedge ref_clk);
      sclk_run <= 1'b0;
      wr(OFS_TX_CTRL, 8'h90);
      wr(OFS_DIVISOR, 8'h08);
      vote(2'h0, 1'b0);
      vote(2'h2, 1'b0);
      vote(2'h1, 1'b1);
      vote(2'h3, 1'b1);
      sts_in <= 4'h5;
      wr(OFS_RX_CTRL, 8'hFF);
      rd(OFS_RX_CTRL);
      chk("rx readback", 16'h00FD, d);
      @(negedge ref_clk);
      chk("read data release", 16'h0000, {8'h00, reg_rdata});
      wr(2'h3, 8'hFF);
      rd(2'h3);
      chk("unmapped read", 16'h0000, d);
      @(posedge ref_clk);
      nrst <= 1'b0;
      sts_in <= 4'h0;
      repeat (2) @(posedge ref_clk);
      nrst <= 1'b1;
      rd(OFS_DIVISOR);
      chk("divisor after reset", 16'h0000, d);
      rd(OFS_RX_CTRL);
      chk("rx after reset", 16'h0000, d);
      $display("awkward tests done");
      final_report();
   end
endmodule

// ===== bench/ubrg_shift_model.sv
// Behavioural serial shifter beside the rate generator.
// Assumes the bench sets status levels, pin pattern and slave clock run.
module ubrg_shift_model (
   // Clock, reset, rate tick, bench controls
   input  wire logic        ref_clk,
   input  wire logic        nrst,
   input  wire logic        rate_tick,
   input  wire logic [3:0]  sts_in,
   input  wire logic [1:0]  pin_mode,
   input  wire logic        sclk_run,
   // Shifter pins
   output      logic        tx_shift_empty,
   output      logic        rx_frame_err,
   output      logic        rx_overrun,
   output      logic        rx_ninth_bit,
   output      logic        receive_data_pin,
   output      logic        ext_clk,
   // Tick count and spacing
   output      logic [15:0] ticks,
   output      logic [15:0] gap
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] since;
   logic [2:0]  ph5;
   ///////////////////////////////////////////////////////////////////
   assign {tx_shift_empty, rx_frame_err, rx_overrun, rx_ninth_bit} = sts_in;
   // Lone glitch every fifth cycle
   assign receive_data_pin = pin_mode[1] ? (ph5 == 3'h0) ^ pin_mode[0] : pin_mode[0];
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ph5     <= 3'h0;
         ext_clk <= 1'b0;
         ticks   <= 16'h0000;
         gap     <= 16'h0000;
         since   <= 16'h0000;
      end else begin
         ph5   <= (ph5 == 3'h4) ? 3'h0 : ph5 + 3'h1;
         since <= rate_tick ? 16'h0000 : since + 16'h0001;
         // Serial clock stands low outside frames
         if (!sclk_run) begin
            ext_clk <= 1'b0;
         end else if (ph5 == 3'h4) begin
            ext_clk <= ~ext_clk;
         end
         if (rate_tick) begin
            ticks <= ticks + 16'h0001;
            gap   <= since + 16'h0001;
         end
      end
   end
endmodule

// ===== src/ubrg_pkg.sv
// Constants for the serial port rate generator.
// Assumes a single 250 MHz clock and an 8-bit register port.
package ubrg_pkg;
   // Clock
   localparam int CLK_PERIOD_NS = 4;

   // Register indices on the 2-bit address port
   localparam logic [1:0] OFS_TX_CTRL = 2'h0;
   localparam logic [1:0] OFS_RX_CTRL = 2'h1;
   localparam logic [1:0] OFS_DIVISOR = 2'h2;

   // Transmit control fields
   localparam int TX_CLK_SRC = 7;
   localparam int TX_NINE    = 6;
   localparam int TX_EN      = 5;
   localparam int TX_SYNC    = 4;
   localparam int TX_UNIMPL  = 3;
   localparam int TX_HS      = 2;
   localparam int TX_EMPTY   = 1;
   localparam int TX_NINTH   = 0;

   // Receive control fields
   localparam int RX_PORT_EN = 7;
   localparam int RX_NINE    = 6;
   localparam int RX_SINGLE  = 5;
   localparam int RX_CONT    = 4;
   localparam int RX_ADDR_EN = 3;
   localparam int RX_FRAME   = 2;
   localparam int RX_OVER    = 1;
   localparam int RX_NINTH   = 0;

   // Writable masks
   localparam logic [7:0] TX_WR_MASK = 8'hF5;
   localparam logic [7:0] RX_WR_MASK = 8'hF8;

   // Values after reset
   localparam logic [7:0] TX_CTRL_RST = 8'h02;
   localparam logic [7:0] RX_CTRL_RST = 8'h00;
   localparam logic [7:0] DIVISOR_RST = 8'h00;

   // Prescale limits (divide factor minus one)
   localparam logic [5:0] PRE_ASYNC_LO = 6'h3F;
   localparam logic [5:0] PRE_ASYNC_HI = 6'h0F;
   localparam logic [5:0] PRE_SYNC     = 6'h03;

   // Samples before the period end used by the vote
   localparam logic [5:0] VOTE_LEAD = 6'h02;
endpackage

// ===== src/ubrg_top.sv
// Baud rate generator with receive pin majority vote.
// Assumes all inputs synchronous to ref_clk; shifter logic consumes rate_tick.
//
// The strobed register port and the register offsets were decided locally.

//////////////////////////////////////////////////////////////////////////////
module ubrg_top (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   // Register port
   input  wire logic [1:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output      logic [7:0] reg_rdata,
   // Shifter status
   input  wire logic       tx_shift_empty,
   input  wire logic       rx_frame_err,
   input  wire logic       rx_overrun,
   input  wire logic       rx_ninth_bit,
   // External serial clock in slave mode
   input  wire logic       ext_clk,
   // Receive pin
   input  wire logic       receive_data_pin,
   // To shifters
   output      logic       rate_tick,
   output      logic       rx_level,
   output      logic [7:0] tx_ctrl,
   output      logic [7:0] rx_ctrl
);
   import ubrg_pkg::*;

   ///////////////////////////////////////////////////////////////////////////
   // Register storage
   logic [7:0] baud_divisor;
   logic [7:0] tx_store;
   logic [7:0] rx_store;
   logic [7:0] tx_status_control;
   logic [7:0] rx_status_control;

   // Generator state
   logic [7:0] timer;
   logic [5:0] pre_cnt;
   logic [5:0] pre_max;
   logic       pre_wrap;
   logic       int_fire;
   logic       ext_prev;
   logic       ext_edge;
   logic       mode_sync;
   logic       mode_slave;
   logic       div_wr;

   // Vote state
   logic       samp_a;
   logic       samp_b;
   logic       vote_win;

   function automatic logic decode(input logic [1:0] a,
                                   input logic [1:0] ofs);
      decode = (a == ofs);
   endfunction

   function automatic logic majority(input logic a,
                                     input logic b,
                                     input logic c);
      majority = (a & b) | (a & c) | (b & c);
   endfunction

   ///////////////////////////////////////////////////////////////////////////
   // Control register writes
   assign div_wr = reg_wr && decode(reg_addr, OFS_DIVISOR);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         tx_store <= TX_CTRL_RST & TX_WR_MASK;
      end else if (reg_wr && decode(reg_addr, OFS_TX_CTRL)) begin
         tx_store <= reg_wdata & TX_WR_MASK;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rx_store <= RX_CTRL_RST & RX_WR_MASK;
      end else if (reg_wr && decode(reg_addr, OFS_RX_CTRL)) begin
         rx_store <= reg_wdata & RX_WR_MASK;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         baud_divisor <= DIVISOR_RST;
      end else if (div_wr) begin
         baud_divisor <= reg_wdata;
      end
   end

   // Composed views with live status bits
   always_comb begin
      tx_status_control = tx_store;
      tx_status_control[TX_EMPTY]  = tx_shift_empty;
      tx_status_control[TX_UNIMPL] = 1'b0;
      rx_status_control = rx_store;
      rx_status_control[RX_FRAME] = rx_frame_err;
      rx_status_control[RX_OVER]  = rx_overrun;
      rx_status_control[RX_NINTH] = rx_ninth_bit;
   end

   ///////////////////////////////////////////////////////////////////////////
   // Read port, data one cycle after strobe
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            OFS_TX_CTRL: reg_rdata <= tx_status_control;
            OFS_RX_CTRL: reg_rdata <= rx_status_control;
            OFS_DIVISOR: reg_rdata <= baud_divisor;
            default:     reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // Control mirrors for the shifters
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         tx_ctrl <= TX_CTRL_RST;
         rx_ctrl <= RX_CTRL_RST;
      end else begin
         tx_ctrl <= tx_status_control;
         rx_ctrl <= rx_status_control;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Mode and prescale selection
   assign mode_sync  = tx_store[TX_SYNC];
   assign mode_slave = mode_sync && !tx_store[TX_CLK_SRC];

   always_comb begin
      if (mode_sync) begin
         pre_max = PRE_SYNC;
      end else if (tx_store[TX_HS]) begin
         pre_max = PRE_ASYNC_HI;
      end else begin
         pre_max = PRE_ASYNC_LO;
      end
   end

   assign pre_wrap = (pre_cnt >= pre_max);
   assign int_fire = pre_wrap && (timer == 8'h00) && !div_wr;

   // Prescaler, cleared by divisor write
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pre_cnt <= 6'h00;
      end else if (div_wr) begin
         pre_cnt <= 6'h00;
      end else if (pre_wrap) begin
         pre_cnt <= 6'h00;
      end else begin
         pre_cnt <= pre_cnt + 6'h01;
      end
   end

   // Down timer with reload from divisor
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         timer <= 8'h00;
      end else if (div_wr) begin
         timer <= 8'h00;
      end else if (pre_wrap) begin
         if (timer == 8'h00) begin
            timer <= baud_divisor;
         end else begin
            timer <= timer - 8'h01;
         end
      end
   end

   // External clock rising edge for slave mode
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ext_prev <= 1'b0;
      end else begin
         ext_prev <= ext_clk;
      end
   end

   assign ext_edge = ext_clk && !ext_prev;

   // Rate tick source chosen by master or slave role
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rate_tick <= 1'b0;
      end else if (mode_slave) begin
         rate_tick <= ext_edge;
      end else begin
         rate_tick <= int_fire;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Three samples at the end of each bit period
   // Subtract from the limit; a 6-bit sum would wrap near a limit of 63
   assign vote_win = (timer == 8'h00) && !div_wr
                     && (pre_cnt >= pre_max - VOTE_LEAD);

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         samp_a <= 1'b1;
         samp_b <= 1'b1;
      end else if (vote_win) begin
         samp_a <= samp_b;
         samp_b <= receive_data_pin;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rx_level <= 1'b1;
      end else if (int_fire) begin
         rx_level <= majority(samp_a, samp_b, receive_data_pin);
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // Checks
   a_div_clears: assert property (@(posedge ref_clk) disable iff (!nrst)
      div_wr |=> (timer == 8'h00) && (pre_cnt == 6'h00))
      else $error("divisor write did not clear timer");

   a_reload_div: assert property (@(posedge ref_clk) disable iff (!nrst)
      int_fire |=> timer == $past(baud_divisor))
      else $error("timer did not reload from divisor");

   a_tick_follow: assert property (@(posedge ref_clk) disable iff (!nrst)
      (int_fire && !mode_slave) |=> rate_tick)
      else $error("period end gave no tick");

   a_tick_single: assert property (@(posedge ref_clk) disable iff (!nrst)
      (rate_tick && !mode_slave && !$past(mode_slave))
      |=> !rate_tick [*3])
      else $error("internal ticks closer than four cycles");

   a_sync_prescale: assert property (@(posedge ref_clk) disable iff (!nrst)
      mode_sync |-> pre_max == 6'h03)
      else $error("sync mode prescale not four");

   a_async_prescale: assert property (@(posedge ref_clk) disable iff (!nrst)
      !mode_sync |-> pre_max == (tx_store[TX_HS] ? 6'h0F : 6'h3F))
      else $error("async prescale wrong");

   a_slave_edge: assert property (@(posedge ref_clk) disable iff (!nrst)
      (mode_slave && ext_clk && !ext_prev) |=> rate_tick)
      else $error("slave edge gave no tick");

   a_unimpl_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
      (reg_rd && reg_addr == OFS_TX_CTRL) |=> !reg_rdata[TX_UNIMPL])
      else $error("unimplemented bit read as one");

   a_vote_result: assert property (@(posedge ref_clk) disable iff (!nrst)
      int_fire |=> rx_level == majority($past(samp_a), $past(samp_b),
                                        $past(receive_data_pin)))
      else $error("vote result wrong");

   a_div_readback: assert property (@(posedge ref_clk) disable iff (!nrst)
      (reg_rd && reg_addr == OFS_DIVISOR) |=> reg_rdata == $past(baud_divisor))
      else $error("divisor readback wrong");
endmodule
